//--- ums_pkg.sv
/*
 * constants for the modem-status and scratch-pad block of the two serial ports.
 * assumes a byte-wide i/o space with 16-bit addresses, no other bus.
 */
`default_nettype none

package ums_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int IO_ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int LINES = 4;
    localparam int PORTS = 2;

    // ------------------------------------------------------------
    // i/o addresses, index 0 is port 1, index 1 is port 2
    // ------------------------------------------------------------
    localparam logic [IO_ADDR_W-1:0] PORT2_MODEM_LINE_STATUS_ADDR = 16'h02fe;
    localparam logic [IO_ADDR_W-1:0] PORT2_SCRATCH_PAD_ADDR = 16'h02ff;
    localparam logic [IO_ADDR_W-1:0] PORT1_MODEM_LINE_STATUS_ADDR = 16'h03fe;
    localparam logic [IO_ADDR_W-1:0] PORT1_SCRATCH_PAD_ADDR = 16'h03ff;

    // ------------------------------------------------------------
    // modem status layout: live bits in the upper nibble, flags below
    // ------------------------------------------------------------
    localparam int MSR_LIVE_LSB = 4;
    localparam int MSR_FLAG_LSB = 0;
    // line index inside a nibble
    localparam int LINE_CARRIER = 3;
    localparam int LINE_RING = 2;
    localparam int LINE_SET_READY = 1;
    localparam int LINE_CLEAR_SEND = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [LINES-1:0] PIN_IDLE_N = 4'hf;
    localparam logic [LINES-1:0] FLAGS_RESET = 4'h0;
    localparam logic [DATA_W-1:0] SCRATCH_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

endpackage

`default_nettype wire

//--- ums_sync4.sv
/*
 * two-flop synchroniser for the four modem control pins of one port.
 * assumes the pins are asynchronous to clock; idle level is high.
 */
`timescale 1ns/1ps
`default_nettype none

module ums_sync4 (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ums_pkg::LINES-1:0] pins_n,
    output logic [ums_pkg::LINES-1:0] synced_n
);
    import ums_pkg::*;

    typedef struct packed {
        logic [LINES-1:0] stage1;
        logic [LINES-1:0] stage2;
    } ums_sync_state_t;

    ums_sync_state_t state_reg;
    ums_sync_state_t state_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // first stage feeds only the second stage
    always_comb begin
        state_next = state_reg;
        state_next.stage1 = pins_n;
        state_next.stage2 = state_reg.stage1;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // idle high so no false change is seen after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= {PIN_IDLE_N, PIN_IDLE_N};
        end else begin
            state_reg <= state_next;
        end
    end

    assign synced_n = state_reg.stage2;

endmodule

`default_nettype wire

//--- ums_top.sv
/*
 * modem-status and scratch-pad registers of two serial ports.
 * assumes the rest of the uart supplies loopback, modem-control and
 * interrupt-enable bits as levels, and accesses come as one-cycle strobes.
 */
// What this block does
// - live status bits are inverted input pins
// - status: carrier7 ring6 ready5 cts4, flags 3-0
// - loopback: carrier bit follows aux output two
// - loopback: ring bit follows aux output one
// - loopback: set-ready bit follows dtr control
// - loopback: clear-to-send bit follows rts control
// - carrier change flag on either edge
// - ring flag only on active-to-inactive edge
// - set-ready change flag on any change
// - clear-to-send change flag on any change
// - any flag raises interrupt when enabled
// - status read clears flags and interrupt; a change in the read cycle still sets its flag
// - 8-bit read/write scratch register
`timescale 1ns/1ps
`default_nettype none

module ums_top (
    input wire logic clock,
    input wire logic rst,
    // i/o access, one-cycle strobes
    input wire logic [ums_pkg::IO_ADDR_W-1:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [ums_pkg::DATA_W-1:0] io_wdata,
    output logic [ums_pkg::DATA_W-1:0] io_rdata,
    output logic io_rd_ack,
    // modem pins, index 0 port 1, index 1 port 2
    input wire logic [ums_pkg::PORTS-1:0] carrier_detect_pin_n,
    input wire logic [ums_pkg::PORTS-1:0] ring_pin_n,
    input wire logic [ums_pkg::PORTS-1:0] set_ready_pin_n,
    input wire logic [ums_pkg::PORTS-1:0] clear_send_pin_n,
    // modem control and interrupt enable bits from the uart core
    input wire logic [ums_pkg::PORTS-1:0] loopback_mode,
    input wire logic [ums_pkg::PORTS-1:0] aux_output_one,
    input wire logic [ums_pkg::PORTS-1:0] aux_output_two,
    input wire logic [ums_pkg::PORTS-1:0] dtr_ctrl,
    input wire logic [ums_pkg::PORTS-1:0] rts_ctrl,
    input wire logic [ums_pkg::PORTS-1:0] modem_irq_enable,
    output logic [ums_pkg::PORTS-1:0] modem_status_irq
);
    import ums_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LINES-1:0] prev;
        logic primed;
        logic [LINES-1:0] flags;
        logic [DATA_W-1:0] scratch;
        logic irq;
    } ums_port_t;

    typedef struct packed {
        ums_port_t [PORTS-1:0] port;
        logic [DATA_W-1:0] rdata;
        logic rd_ack;
    } ums_state_t;

    ums_state_t state_reg;
    ums_state_t state_next;

    logic [LINES-1:0] synced_n [PORTS];
    logic [LINES-1:0] live [PORTS];
    logic [LINES-1:0] change [PORTS];
    logic [LINES-1:0] set_flags [PORTS];
    logic [LINES-1:0] loop_src [PORTS];
    logic [PORTS-1:0] hit_status;
    logic [PORTS-1:0] hit_scratch;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : gen_sync
            ums_sync4 u_sync (
                .clock(clock),
                .rst(rst),
                .pins_n({carrier_detect_pin_n[g], ring_pin_n[g], set_ready_pin_n[g], clear_send_pin_n[g]}),
                .synced_n(synced_n[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        hit_status[0] = (io_addr == PORT1_MODEM_LINE_STATUS_ADDR);
        hit_status[1] = (io_addr == PORT2_MODEM_LINE_STATUS_ADDR);
        hit_scratch[0] = (io_addr == PORT1_SCRATCH_PAD_ADDR);
        hit_scratch[1] = (io_addr == PORT2_SCRATCH_PAD_ADDR);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rd_ack = 1'b0;
        for (int p = 0; p < PORTS; p++) begin
            // loopback sources, aux two
            // to carrier, aux one to ring
            loop_src[p][LINE_CARRIER] = aux_output_two[p];
            loop_src[p][LINE_RING] = aux_output_one[p];
            // dtr to ready
            // rts to clear-to-send
            loop_src[p][LINE_SET_READY] = dtr_ctrl[p];
            loop_src[p][LINE_CLEAR_SEND] = rts_ctrl[p];
            live[p] = loopback_mode[p] ? loop_src[p] : ~synced_n[p];

            // first cycle after reset only primes, avoiding a false change
            change[p] = state_reg.port[p].primed ? (live[p] ^ state_reg.port[p].prev) : FLAGS_RESET;
            set_flags[p][LINE_CARRIER] = change[p][LINE_CARRIER];
            set_flags[p][LINE_RING] = change[p][LINE_RING] & state_reg.port[p].prev[LINE_RING];
            set_flags[p][LINE_SET_READY] = change[p][LINE_SET_READY];
            set_flags[p][LINE_CLEAR_SEND] = change[p][LINE_CLEAR_SEND];

            state_next.port[p].prev = live[p];
            state_next.port[p].primed = 1'b1;

            if (io_rd && hit_status[p]) begin
                state_next.port[p].flags = set_flags[p];
            end else begin
                state_next.port[p].flags = state_reg.port[p].flags | set_flags[p];
            end

            state_next.port[p].irq = modem_irq_enable[p] & (|state_next.port[p].flags);

            if (io_wr && hit_scratch[p]) begin
                state_next.port[p].scratch = io_wdata;
            end
        end

        // status reads are write-protected; writes there are dropped
        if (io_rd) begin
            state_next.rd_ack = 1'b1;
            state_next.rdata = UNMAPPED_READ;
            for (int p = 0; p < PORTS; p++) begin
                if (hit_status[p]) begin
                    state_next.rdata = {live[p], state_reg.port[p].flags};
                end
                if (hit_scratch[p]) begin
                    state_next.rdata = state_reg.port[p].scratch;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < PORTS; p++) begin
                state_reg.port[p].prev <= FLAGS_RESET;
                state_reg.port[p].primed <= 1'b0;
                state_reg.port[p].flags <= FLAGS_RESET;
                state_reg.port[p].scratch <= SCRATCH_RESET;
                state_reg.port[p].irq <= 1'b0;
            end
            state_reg.rdata <= UNMAPPED_READ;
            state_reg.rd_ack <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign io_rdata = state_reg.rdata;
    assign io_rd_ack = state_reg.rd_ack;
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            modem_status_irq[p] = state_reg.port[p].irq;
        end
    end

endmodule

`default_nettype wire

//--- ums_modem_model.sv
/* modem-side model driving the active-low control pins of both ports.
   assumes the bench names asserted lines, per port bit3 carrier to bit0 cts. */
`timescale 1ns/1ps
`default_nettype none
module ums_modem_model (
    input wire logic [7:0] line_on,
    output logic [1:0] carrier_detect_pin_n,
    output logic [1:0] ring_pin_n,
    output logic [1:0] set_ready_pin_n,
    output logic [1:0] clear_send_pin_n
);
    // pins idle high; no pull issue as the model always drives them
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            {carrier_detect_pin_n[p], ring_pin_n[p], set_ready_pin_n[p], clear_send_pin_n[p]} = ~line_on[4*p +: 4];
        end
    end
endmodule
`default_nettype wire

//--- ums_top_assertions.sv
/* checker for ums_top, status lines of port 1 and irq of both ports.
   assumes it is bound to ums_top by the statement at the foot. */
`timescale 1ns/1ps
`default_nettype none
module ums_top_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ums_pkg::IO_ADDR_W-1:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [ums_pkg::DATA_W-1:0] io_wdata,
    input wire logic [ums_pkg::DATA_W-1:0] io_rdata,
    input wire logic io_rd_ack,
    input wire logic [ums_pkg::PORTS-1:0] carrier_detect_pin_n,
    input wire logic [ums_pkg::PORTS-1:0] ring_pin_n,
    input wire logic [ums_pkg::PORTS-1:0] set_ready_pin_n,
    input wire logic [ums_pkg::PORTS-1:0] clear_send_pin_n,
    input wire logic [ums_pkg::PORTS-1:0] loopback_mode,
    input wire logic [ums_pkg::PORTS-1:0] aux_output_one,
    input wire logic [ums_pkg::PORTS-1:0] aux_output_two,
    input wire logic [ums_pkg::PORTS-1:0] dtr_ctrl,
    input wire logic [ums_pkg::PORTS-1:0] rts_ctrl,
    input wire logic [ums_pkg::PORTS-1:0] modem_irq_enable,
    input wire logic [ums_pkg::PORTS-1:0] modem_status_irq
);
    import ums_pkg::*;
    logic [3:0] pv;
    assign pv = {carrier_detect_pin_n[0], ring_pin_n[0], set_ready_pin_n[0], clear_send_pin_n[0]};
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_ack_after_read: assert property (io_rd |=> io_rd_ack) else $error("read not acknowledged");
    a_ack_only_read: assert property (io_rd_ack |-> $past(io_rd)) else $error("acknowledge without read");
    a_rdata_holds: assert property (!io_rd_ack |-> $stable(io_rdata)) else $error("read data moved");
    a_irq_masked: assert property ((modem_status_irq & ~$past(modem_irq_enable)) == 2'b00)
        else $error("masked interrupt raised");
    a_live_inverted: assert property ((!loopback_mode[0] && $stable(pv)) [*3] ##1
        (io_rd && io_addr == PORT1_MODEM_LINE_STATUS_ADDR && !loopback_mode[0] && $stable(pv))
        |=> io_rdata[7:4] == ~$past(pv)) else $error("live bits not inverted pins");
    a_loop_carrier_ring: assert property (io_rd && io_addr == PORT1_MODEM_LINE_STATUS_ADDR
        && loopback_mode[0] |=> io_rdata[7:6] == {$past(aux_output_two[0]), $past(aux_output_one[0])})
        else $error("loopback carrier/ring");
    a_loop_ready_cts: assert property (io_rd && io_addr == PORT1_MODEM_LINE_STATUS_ADDR
        && loopback_mode[0] |=> io_rdata[5:4] == {$past(dtr_ctrl[0]), $past(rts_ctrl[0])})
        else $error("loopback ready/cts");
    a_scratch_holds: assert property (io_wr && io_addr == PORT1_SCRATCH_PAD_ADDR ##1 !io_wr ##1
        (io_rd && !io_wr && io_addr == PORT1_SCRATCH_PAD_ADDR) |=> io_rdata == $past(io_wdata, 3))
        else $error("scratch lost data");
endmodule
bind ums_top ums_top_chk chk_u (.clock, .rst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rd_ack,
    .carrier_detect_pin_n, .ring_pin_n, .set_ready_pin_n, .clear_send_pin_n, .loopback_mode,
    .aux_output_one, .aux_output_two, .dtr_ctrl, .rts_ctrl, .modem_irq_enable, .modem_status_irq);
`default_nettype wire

//--- uart_modem_status_scratch_tb.sv
/* self-checking bench for ums_top with a modem model on both ports.
   assumes ums_pkg, the model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_scratch_tb;
    import ums_pkg::*;
    logic clock = 1'b0, rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0, io_rd_ack;
    logic [IO_ADDR_W-1:0] io_addr = '0, sa;
    logic [DATA_W-1:0] io_wdata = '0, io_rdata, f;
    logic [PORTS-1:0] carrier_detect_pin_n, ring_pin_n, set_ready_pin_n, clear_send_pin_n, modem_status_irq;
    logic [PORTS-1:0] loopback_mode = '0, aux_output_one = '0, aux_output_two = '0, dtr_ctrl = '0, rts_ctrl = '0;
    logic [PORTS-1:0] modem_irq_enable = 2'b01;
    logic [7:0] line_on = '0;
    int bad_count = 0, n_compared = 0;
    ums_modem_model modem_u (.line_on, .carrier_detect_pin_n, .ring_pin_n, .set_ready_pin_n, .clear_send_pin_n);
    ums_top dut_u (.clock, .rst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rd_ack,
        .carrier_detect_pin_n, .ring_pin_n, .set_ready_pin_n, .clear_send_pin_n, .loopback_mode,
        .aux_output_one, .aux_output_two, .dtr_ctrl, .rts_ctrl, .modem_irq_enable, .modem_status_irq);
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one strobe per access, then an idle cycle so strobes never re-rise in one step
    task automatic acc(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        {io_rd, io_wr, io_addr, io_wdata} = {rd, wr, a, d};
        @(negedge clock);
        {io_rd, io_wr} = 2'b00;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] mask);
        acc(1'b1, 1'b0, a, 8'h00);
        chk("read ack", 8'h01, {7'h00, io_rd_ack});
        chk("read data", exp, io_rdata & mask);
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        give_verdict;
    end
    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        rd(PORT1_MODEM_LINE_STATUS_ADDR, 8'h00, 8'hff);
        rd(PORT2_SCRATCH_PAD_ADDR, SCRATCH_RESET, 8'hff);
        acc(1'b0, 1'b1, PORT2_SCRATCH_PAD_ADDR, 8'h5a);
        acc(1'b0, 1'b1, PORT1_MODEM_LINE_STATUS_ADDR, 8'hff);
        acc(1'b0, 1'b1, PORT1_SCRATCH_PAD_ADDR, 8'ha5);
        rd(PORT1_SCRATCH_PAD_ADDR, 8'ha5, 8'hff);
        rd(PORT2_SCRATCH_PAD_ADDR, 8'h5a, 8'hff);
        rd(PORT1_MODEM_LINE_STATUS_ADDR, 8'h00, 8'hff);
        rd(16'h0300, UNMAPPED_READ, 8'hff);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                sa = p ? PORT2_MODEM_LINE_STATUS_ADDR : PORT1_MODEM_LINE_STATUS_ADDR;
                // ring raises no flag when it asserts, only when it lets go
                f = (i == LINE_RING) ? 8'h00 : 8'h01 << i;
                line_on[4*p+i] = 1'b1;
                repeat (5) @(negedge clock);
                chk("irq", {7'h00, f != 0 && p == 0}, {7'h00, modem_status_irq[p]});
                rd(sa, (8'h10 << i) | f, 8'hff);
                rd(sa, 8'h10 << i, 8'hff);
                chk("irq", 8'h00, {7'h00, modem_status_irq[p]});
                line_on[4*p+i] = 1'b0;
                repeat (5) @(negedge clock);
                rd(sa, 8'h01 << i, 8'hff);
                rd(sa, 8'h00, 8'hff);
            end
        end
        // change timed to land on the read edge
        line_on[LINE_CARRIER] = 1'b1;
        @(negedge clock);
        rd(PORT1_MODEM_LINE_STATUS_ADDR, 8'h80, 8'hff);
        rd(PORT1_MODEM_LINE_STATUS_ADDR, 8'h88, 8'hff);
        // unmasking a pending flag raises the request
        line_on[4+LINE_CARRIER] = 1'b1;
        repeat (5) @(negedge clock);
        chk("irq", 8'h00, {7'h00, modem_status_irq[1]});
        modem_irq_enable = 2'b11;
        @(negedge clock);
        chk("irq", 8'h01, {7'h00, modem_status_irq[1]});
        rd(PORT2_MODEM_LINE_STATUS_ADDR, 8'h88, 8'hff);
        chk("irq", 8'h00, {7'h00, modem_status_irq[1]});
        line_on = '0;
        repeat (5) @(negedge clock);
        rd(PORT1_MODEM_LINE_STATUS_ADDR, 8'h08, 8'hff);
        rd(PORT2_MODEM_LINE_STATUS_ADDR, 8'h08, 8'hff);
        loopback_mode = 2'b11;
        for (int v = 0; v < 16; v += 5) begin
            {aux_output_two, aux_output_one, dtr_ctrl, rts_ctrl} = {{2{v[3]}}, {2{v[2]}}, {2{v[1]}}, {2{v[0]}}};
            rd(PORT1_MODEM_LINE_STATUS_ADDR, {v[3:0], 4'h0}, 8'hf0);
            rd(PORT2_MODEM_LINE_STATUS_ADDR, {v[3:0], 4'h0}, 8'hf0);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
